// ==== core/dpdc_chan.sv ====
package dpdc_pkg;
  // channel count and preset range
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned BCD_W = 12;
  localparam logic [9:0] PRESET_MAX = 10'h3e7;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT0 = 8'h08;
  localparam logic [7:0] OFS_COUNT1 = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_PRESET0 = 8'h1c;
  localparam logic [7:0] OFS_PRESET1 = 8'h20;

  // field positions: channel n sits at bit n in every per-channel register
  localparam int unsigned BIT_CH0 = 0;
  localparam int unsigned BIT_CH1 = 1;

  // reset values
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [1:0] RST_IRQ_EN = 2'h0;
  localparam logic [1:0] RST_IRQ_STAT = 2'h0;
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [11:0] RST_PRESET = 12'h000;
  localparam logic [31:0] RST_HRDATA = 32'h0000_0000;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // three bcd digits to binary; a digit above nine is read as nine
  function automatic logic [9:0] dpdc_bcd2bin(input logic [11:0] bcd);
    logic [3:0] d2;
    logic [3:0] d1;
    logic [3:0] d0;
    d2 = (bcd[11:8] > BCD_DIGIT_MAX) ? BCD_DIGIT_MAX : bcd[11:8];
    d1 = (bcd[7:4] > BCD_DIGIT_MAX) ? BCD_DIGIT_MAX : bcd[7:4];
    d0 = (bcd[3:0] > BCD_DIGIT_MAX) ? BCD_DIGIT_MAX : bcd[3:0];
    // widen before multiplying so the hundreds product cannot wrap
    return (10'(d2) * 10'd100) + (10'(d1) * 10'd10) + 10'(d0);
  endfunction : dpdc_bcd2bin
endpackage : dpdc_pkg

`timescale 1ns/1ps
`default_nettype none

module dpdc_chan
  import dpdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic cnt_pin,
  input wire logic [dpdc_pkg::BCD_W-1:0] preset_pin,
  input wire logic enable,
  output logic [dpdc_pkg::CNT_W-1:0] count,
  output logic [dpdc_pkg::CNT_W-1:0] preset,
  output logic done
);

  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic pin_lvl_ff;
  logic [BCD_W-1:0] pre_s1_ff;
  logic [BCD_W-1:0] pre_s2_ff;
  logic [BCD_W-1:0] pre_s3_ff;
  logic [BCD_W-1:0] pre_lvl_ff;
  logic [CNT_W-1:0] count_ff;
  logic done_ff;
  logic [CNT_W-1:0] nxt_count;
  wire pin_agree;
  wire pin_rise;
  wire pre_agree;
  wire [CNT_W-1:0] preset_bin;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling: a level is accepted only once stages two and three agree
  assign pin_agree = (pin_s2_ff == pin_s3_ff);
  assign pin_rise = pin_agree && pin_s2_ff && !pin_lvl_ff; // RL12
  assign pre_agree = (pre_s2_ff == pre_s3_ff);
  assign preset_bin = dpdc_bcd2bin(pre_lvl_ff); // RL5

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      pin_lvl_ff <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_ff <= cnt_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_lvl_ff <= pin_agree ? pin_s2_ff : pin_lvl_ff; // RL12
    end
  end

  // the thumbwheel code can bounce while being turned, so it is filtered too
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_s1_ff <= RST_PRESET;
      pre_s2_ff <= RST_PRESET;
      pre_s3_ff <= RST_PRESET;
      pre_lvl_ff <= RST_PRESET;
    end
    else if (ce)
    begin
      pre_s1_ff <= preset_pin;
      pre_s2_ff <= pre_s1_ff;
      pre_s3_ff <= pre_s2_ff;
      pre_lvl_ff <= pre_agree ? pre_s2_ff : pre_lvl_ff; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // down counter: held at preset while disabled, stops at zero
  always_comb
  begin
    nxt_count = count_ff;
    if (!enable)
      nxt_count = preset_bin; // RL11
    else if (pin_rise && (count_ff != RST_COUNT))
      nxt_count = count_ff - 10'h001; // RL2 RL6 RL10
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_ff <= RST_COUNT;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      count_ff <= nxt_count;
      done_ff <= enable && (nxt_count == RST_COUNT); // RL3 RL12
    end
  end

  assign count = count_ff;
  assign preset = preset_bin;
  assign done = done_ff;

endmodule : dpdc_chan

`default_nettype wire

// ==== core/dpdc_top.sv ====
// What this block does
// RL1 - two counting channels run side by side and share no state at all.
// RL2 - a channel loads its preset and steps down once per counted pulse, ending at zero.
// RL3 - when a channel reaches zero its output is driven high.
// RL4 - in that same event its indicator lights and its status bit reads 1.
// RL5 - each preset is a three-digit decimal 0 to 999 taken from selector pins, not the bus.
// RL6 - every pulse is counted at rates up to 500 Hz.
// RL7 - the block looks like a two-channel digital unit, channel n at bit n.
// RL8 - software enables and resets each channel by writing that channel's control bit.
// RL9 - software reads each channel's zero-reached status at bit 0 or 1.
// RL10 - pulses are ignored until the channel has been enabled.
// RL11 - resetting a channel reloads the preset, drops the output and clears status and indicator.
// RL12 - count inputs are synchronised, counted on their rising edge, and hold at zero until reset.
`timescale 1ns/1ps
`default_nettype none

module dpdc_top
  import dpdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [dpdc_pkg::NUM_CH-1:0] cnt_pin,
  input wire logic [dpdc_pkg::BCD_W-1:0] preset0_pin,
  input wire logic [dpdc_pkg::BCD_W-1:0] preset1_pin,
  output logic [dpdc_pkg::NUM_CH-1:0] zero_out,
  output logic [dpdc_pkg::NUM_CH-1:0] zero_led,
  output logic irq
);

  // bus state
  logic act_ff;
  logic wr_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  // control and interrupt state
  logic [NUM_CH-1:0] ctrl_ff;
  logic [NUM_CH-1:0] irq_en_ff;
  logic [NUM_CH-1:0] irq_stat_ff;
  logic [NUM_CH-1:0] done_d_ff;
  logic [NUM_CH-1:0] zero_out_ff;
  logic [NUM_CH-1:0] zero_led_ff;
  logic irq_ff;
  logic [NUM_CH-1:0] nxt_irq_stat;
  logic [NUM_CH-1:0] nxt_ctrl;
  logic [NUM_CH-1:0] nxt_irq_en;
  // channel results
  logic [CNT_W-1:0] cnt_val [NUM_CH];
  logic [CNT_W-1:0] pre_val [NUM_CH];
  logic [NUM_CH-1:0] chan_done;
  logic [BCD_W-1:0] preset_pins [NUM_CH];

  ////////////////////////////////////////////////////////////////////////////
  // address phase decode
  wire addr_take;
  wire rd_take;
  wire wr_data;
  wire wr_ctrl;
  wire wr_irq_clr;
  wire wr_irq_en;
  wire [NUM_CH-1:0] wdata_ch;
  wire [NUM_CH-1:0] done_rise;
  logic [31:0] rd_mux;

  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_take = addr_take && !hwrite;
  assign wr_data = act_ff && wr_ff;
  assign wr_ctrl = wr_data && (addr_ff == OFS_CTRL);
  assign wr_irq_clr = wr_data && (addr_ff == OFS_IRQ_CLR);
  assign wr_irq_en = wr_data && (addr_ff == OFS_IRQ_EN);
  assign wdata_ch = hwdata[NUM_CH-1:0]; // RL7

  // read mux; unmapped and write-only offsets read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_CTRL: rd_mux = {30'h0, ctrl_ff};
      OFS_STATUS: rd_mux = {30'h0, zero_out_ff}; // RL4 RL9
      OFS_COUNT0: rd_mux = {22'h0, cnt_val[BIT_CH0]};
      OFS_COUNT1: rd_mux = {22'h0, cnt_val[BIT_CH1]};
      OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_ff};
      OFS_IRQ_EN: rd_mux = {30'h0, irq_en_ff};
      OFS_PRESET0: rd_mux = {22'h0, pre_val[BIT_CH0]};
      OFS_PRESET1: rd_mux = {22'h0, pre_val[BIT_CH1]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, so hreadyout stays high and the
  // read word is latched at the address phase to come straight from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= OFS_CTRL;
      hrdata_ff <= RST_HRDATA;
      hreadyout_ff <= 1'b1;
    end
    else if (ce)
    begin
      act_ff <= addr_take;
      wr_ff <= hwrite;
      addr_ff <= haddr[7:0];
      hrdata_ff <= rd_take ? rd_mux : hrdata_ff;
      hreadyout_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and interrupt register next values
  assign nxt_ctrl = wr_ctrl ? wdata_ch : ctrl_ff; // RL8
  assign nxt_irq_en = wr_irq_en ? wdata_ch : irq_en_ff;
  assign done_rise = chan_done & ~done_d_ff;

  // a fresh event beats a clear landing in the same cycle
  always_comb
  begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_irq_clr)
      nxt_irq_stat = nxt_irq_stat & ~wdata_ch;
    nxt_irq_stat = nxt_irq_stat | done_rise;
  end

  // control bit 1 enables a channel, 0 holds it in reset at its preset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= RST_CTRL;
      irq_en_ff <= RST_IRQ_EN;
      irq_stat_ff <= RST_IRQ_STAT;
      done_d_ff <= RST_IRQ_STAT;
      irq_ff <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_ff <= nxt_ctrl; // RL8 RL10
      irq_en_ff <= nxt_irq_en;
      irq_stat_ff <= nxt_irq_stat;
      done_d_ff <= chan_done;
      irq_ff <= |(nxt_irq_stat & nxt_irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels; each owns its own sampler, preset and counter
  assign preset_pins[BIT_CH0] = preset0_pin;
  assign preset_pins[BIT_CH1] = preset1_pin;

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_chan
    dpdc_chan u_chan // RL1
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .cnt_pin(cnt_pin[ch]),
      .preset_pin(preset_pins[ch]),
      .enable(ctrl_ff[ch]), // RL11
      .count(cnt_val[ch]),
      .preset(pre_val[ch]),
      .done(chan_done[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // output and indicator follow the done flag together, one cycle later,
  // so the pin, lamp and status never disagree for more than that cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      zero_out_ff <= RST_IRQ_STAT;
      zero_led_ff <= RST_IRQ_STAT;
    end
    else if (ce)
    begin
      zero_out_ff <= chan_done; // RL3
      zero_led_ff <= chan_done; // RL4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = HRESP_OKAY;
  assign zero_out = zero_out_ff;
  assign zero_led = zero_led_ff;
  assign irq = irq_ff;

endmodule : dpdc_top

`default_nettype wire

// ==== test/dpdc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module dpdc_checker
  import dpdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [dpdc_pkg::NUM_CH-1:0] zero_out,
  input wire logic [dpdc_pkg::NUM_CH-1:0] zero_led,
  input wire logic irq
);
  import dpdc_pkg::*;
  // bus requests taken at this edge
  wire logic rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  wire logic wr_req = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
  logic wv_ff;
  logic [7:0] wa_ff;
  logic [1:0] ctrl_ff, ctrl_q_ff, en_ff, en_q_ff;

  // shadow of control and enable, so outputs can be tied to what software wrote
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {wv_ff, wa_ff, ctrl_ff, ctrl_q_ff, en_ff, en_q_ff} <= '0;
    end
    else
    begin
      wv_ff <= wr_req;
      wa_ff <= haddr[7:0];
      ctrl_q_ff <= ctrl_ff;
      en_q_ff <= en_ff;
      if (wv_ff && wa_ff == OFS_CTRL) ctrl_ff <= hwdata[1:0];
      if (wv_ff && wa_ff == OFS_IRQ_EN) en_ff <= hwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking dck @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("hreadyout dropped");
  okay_resp_a: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  led_follow_a: assert property (zero_led == zero_out)
    else $error("indicator differs from output");
  out_enabled_a: assert property ((zero_out & ~$past(zero_out) & ~ctrl_ff) == 2'h0)
    else $error("output rose on a disabled channel");
  out_drop_a: assert property ($fell(ctrl_ff[1]) |-> ##[0:3] !zero_out[1])
    else $error("output kept after channel reset");
  rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rd_req && haddr[7:0] > OFS_PRESET1 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  preset_range_a: assert property (rd_req && haddr[7:0] == OFS_PRESET0 |=>
    hrdata <= 32'(PRESET_MAX))
    else $error("preset above range");
  irq_mask_a: assert property (en_ff == 2'h0 && en_q_ff == 2'h0 |-> !irq)
    else $error("interrupt while masked");

  cover property ($rose(zero_out[0]));
  cover property ($rose(irq));
  cover property ($fell(ctrl_ff[1]));
endmodule : dpdc_checker

bind dpdc_top dpdc_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .zero_out, .zero_led, .irq);
`default_nettype wire

// ==== test/dpdc_pulse_src.sv ====
`timescale 1ns/1ps
`default_nettype none

module dpdc_pulse_src
(
  input wire logic hclk,
  output logic [1:0] pin
);
  // lines rest low outside bursts; four clocks a level clears the three-flop filter
  initial pin = 2'h0;

  task automatic burst(input int ch, input int n);
    repeat (n)
    begin
      repeat (4) @(posedge hclk);
      pin[ch] <= 1'b1;
      repeat (4) @(posedge hclk);
      pin[ch] <= 1'b0;
    end
  endtask : burst
endmodule : dpdc_pulse_src
`default_nettype wire

// ==== test/test_dual_preset_down_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_dual_preset_down_counter;
  import dpdc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ce = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, irq;
  logic [1:0] cnt_pin, zero_out, zero_led;
  logic [11:0] pre0 = 12'h999, pre1 = 12'h003;
  int fails = 0, total_checks = 0;

  always #2.5 hclk = ~hclk;

  dpdc_pulse_src src (.hclk, .pin(cnt_pin));
  dpdc_top dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cnt_pin, .preset0_pin(pre0),
    .preset1_pin(pre1), .zero_out, .zero_led, .irq);

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // single slave, so hready is ours; the loop bound only cuts a hang short
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
  endtask : wait_ready

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rchk

  // outputs register one edge after the count lands, so poll with a bound
  task automatic wait_zero(input logic [1:0] m);
    int n;
    n = 0;
    while ((zero_out & m) !== m && n < 20)
    begin
      @(posedge hclk);
      n++;
    end
    check("zero_out", 32'(zero_out & m), 32'(m));
    if ((zero_out & m) !== m) wrap_up();
  endtask : wait_zero

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("status", OFS_STATUS, 32'h0);
    rchk("unmapped", 8'h24, 32'h0);
    rchk("preset0", OFS_PRESET0, 32'h3e7);
    rchk("preset1", OFS_PRESET1, 32'h3);
    $display("test reset done");
    // pulses before enabling leave the count alone
    src.burst(1, 2);
    rchk("count1 idle", OFS_COUNT1, 32'h3);
    xfer(1'b1, OFS_IRQ_EN, 32'h2);
    xfer(1'b1, OFS_CTRL, 32'h2);
    src.burst(1, 2);
    rchk("count1 mid", OFS_COUNT1, 32'h1);
    check("early out", 32'(zero_out), 32'h0);
    // a frozen clock enable must swallow a whole pulse
    ce <= 1'b0;
    src.burst(1, 1);
    ce <= 1'b1;
    rchk("count1 frozen", OFS_COUNT1, 32'h1);
    // one pulse beyond the preset: count must hold at zero
    src.burst(1, 2);
    wait_zero(2'h2);
    check("zero_led", 32'(zero_led), 32'h2);
    rchk("count1 zero", OFS_COUNT1, 32'h0);
    rchk("status set", OFS_STATUS, 32'h2);
    rchk("count0 apart", OFS_COUNT0, 32'h3e7);
    rchk("irq stat", OFS_IRQ_STAT, 32'h2);
    check("irq", 32'(irq), 32'h1);
    $display("test count done");
    xfer(1'b1, OFS_IRQ_CLR, 32'h2);
    xfer(1'b1, OFS_CTRL, 32'h0);
    repeat (4) @(posedge hclk);
    rchk("irq cleared", OFS_IRQ_STAT, 32'h0);
    rchk("status off", OFS_STATUS, 32'h0);
    rchk("count1 reload", OFS_COUNT1, 32'h3);
    check("out off", 32'(zero_out), 32'h0);
    $display("test reset channel done");
    // preset zero is reached at once; interrupt stays masked
    pre0 <= 12'h000;
    xfer(1'b1, OFS_IRQ_EN, 32'h0);
    repeat (6) @(posedge hclk);
    xfer(1'b1, OFS_CTRL, 32'h1);
    wait_zero(2'h1);
    check("zero_led ch0", 32'(zero_led), 32'h1);
    rchk("irq stat ch0", OFS_IRQ_STAT, 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    $display("test preset zero done");
    wrap_up();
  end
endmodule : test_dual_preset_down_counter
`default_nettype wire
